// ==== inc/slot_map_pkg.sv ====
// shared types, constants and helpers for the per-sample slot mapper
package slot_map_pkg;

    localparam int unsigned MAX_GROUPS = 8;
    localparam int unsigned SUB_TAG_W = 12;
    localparam int unsigned SAMPLE_W = 4;
    localparam int unsigned PAIR_W = 3;
    localparam int unsigned COUNT_W = 4;
    localparam int unsigned LOG_W = 3;
    localparam int unsigned DISP_W = 4;

    localparam logic [PAIR_W-1:0] PAIR_RESET = 3'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
    localparam logic [DISP_W-1:0] DISP_RESET = 4'h0;
    localparam logic [LOG_W-1:0] LOG_RESET = 3'h0;
    localparam logic [LOG_W-1:0] GROUP_LOG_SIMD8 = 3'h1;
    localparam logic [LOG_W-1:0] GROUP_LOG_SIMD16 = 3'h2;
    localparam logic [LOG_W-1:0] GROUP_LOG_SIMD32 = 3'h3;

    typedef enum logic [1:0] {
        SIMD8 = 2'b00,
        SIMD16 = 2'b01,
        SIMD32 = 2'b10
    } simd_e;

    typedef enum logic [2:0] {
        MS_1X = 3'b000,
        MS_2X = 3'b001,
        MS_4X = 3'b010,
        MS_8X = 3'b011,
        MS_16X = 3'b100
    } msaa_e;

    typedef struct packed {
        logic [SUB_TAG_W-1:0] tag;
        logic [3:0] pixel_mask;
    } subspan_s;

    typedef struct packed {
        logic valid;
        logic [SUB_TAG_W-1:0] tag;
        logic [3:0] pixel_mask;
        logic [SAMPLE_W-1:0] sample;
    } slot_group_s;

    typedef struct packed {
        simd_e simd;
        logic [PAIR_W-1:0] start_pair_index;
        logic last_of_subspan;
        slot_group_s [MAX_GROUPS-1:0] group;
    } dispatch_s;

    // log2 of the number of four-slot groups in a dispatch
    function automatic logic [LOG_W-1:0] group_log2(input simd_e s);
        case (s)
            SIMD8: group_log2 = GROUP_LOG_SIMD8;
            SIMD16: group_log2 = GROUP_LOG_SIMD16;
            default: group_log2 = GROUP_LOG_SIMD32;
        endcase
    endfunction : group_log2

    // log2 of samples shaded per pixel; per-pixel shading collapses to one
    function automatic logic [LOG_W-1:0] sample_log2(input msaa_e m, input logic srs);
        logic [LOG_W-1:0] r;
        r = 3'h0;
        if (srs) begin
            case (m)
                MS_2X: r = 3'h1;
                MS_4X: r = 3'h2;
                MS_8X: r = 3'h3;
                MS_16X: r = 3'h4;
                default: r = 3'h0;
            endcase
        end
        return r;
    endfunction : sample_log2

    function automatic logic [LOG_W-1:0] min_log(input logic [LOG_W-1:0] a,
                                                 input logic [LOG_W-1:0] b);
        return (a < b) ? a : b;
    endfunction : min_log

endpackage : slot_map_pkg

// ==== core/slot_group_fill.sv ====
// combinational fill of slot groups from buffered subspans and a start pair index
`timescale 1ns/1ps
`default_nettype none
module slot_group_fill (
    input wire slot_map_pkg::subspan_s [slot_map_pkg::MAX_GROUPS-1:0] subspans,
    input wire logic [slot_map_pkg::COUNT_W-1:0] subspan_count,
    input wire logic [slot_map_pkg::LOG_W-1:0] group_log,
    input wire logic [slot_map_pkg::LOG_W-1:0] per_sub_log,
    input wire logic [slot_map_pkg::PAIR_W-1:0] start_pair_index,
    output slot_map_pkg::slot_group_s [slot_map_pkg::MAX_GROUPS-1:0] groups
);
    import slot_map_pkg::*;

    always_comb begin
        logic [COUNT_W-1:0] sub_idx;
        logic [SAMPLE_W-1:0] in_sub;
        logic [COUNT_W-1:0] group_cnt;
        sub_idx = COUNT_RESET;
        in_sub = '0;
        group_cnt = COUNT_W'(1) << group_log;
        for (int g = 0; g < MAX_GROUPS; g++) begin
            // groups of one subspan are adjacent, sample index rises by one per group
            sub_idx = COUNT_W'(g) >> per_sub_log;
            in_sub = SAMPLE_W'(g) & SAMPLE_W'((COUNT_W'(1) << per_sub_log) - COUNT_W'(1));
            groups[g].sample = SAMPLE_W'({start_pair_index, 1'b0}) + in_sub;
            groups[g].valid = (COUNT_W'(g) < group_cnt) && (sub_idx < subspan_count);
            groups[g].tag = subspans[sub_idx[2:0]].tag;
            groups[g].pixel_mask = subspans[sub_idx[2:0]].pixel_mask;
        end
    end

endmodule : slot_group_fill
`default_nettype wire

// ==== core/per_sample_slot_mapper.sv ====
// subspan to thread-slot mapper for per-sample pixel shader dispatch
`timescale 1ns/1ps
`default_nettype none
module per_sample_slot_mapper (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // dispatch configuration, taken with the first subspan of each batch
    input wire slot_map_pkg::simd_e dispatch_simd,
    input wire slot_map_pkg::msaa_e num_samples,
    input wire logic sample_rate_shading,
    // subspan stream from the windower unit
    input wire logic sub_valid,
    output logic sub_ready,
    input wire slot_map_pkg::subspan_s sub_data,
    input wire logic sub_flush,
    // dispatch stream to the thread dispatcher
    output logic disp_valid,
    input wire logic disp_ready,
    output slot_map_pkg::dispatch_s disp_data,
    output logic busy
);
    import slot_map_pkg::*;

    typedef enum logic [1:0] {
        ST_COLLECT = 2'b00,
        ST_BUILD = 2'b01,
        ST_ISSUE = 2'b10
    } state_e;

    state_e state_reg;
    state_e state_next;

    subspan_s [MAX_GROUPS-1:0] buf_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;

    simd_e simd_reg;
    logic [LOG_W-1:0] group_log_reg;
    logic [LOG_W-1:0] sample_log_reg;

    logic [DISP_W-1:0] disp_idx_reg;
    logic [PAIR_W-1:0] pair_reg;
    dispatch_s out_reg;

    logic take;
    logic send;
    logic first_take;
    logic [LOG_W-1:0] cfg_group_log;
    logic [LOG_W-1:0] cfg_sample_log;
    logic [LOG_W-1:0] per_sub_log;
    logic [LOG_W-1:0] subs_per_disp_log;
    logic [LOG_W-1:0] disp_per_sub_log;
    logic [COUNT_W-1:0] subs_per_disp;
    logic [DISP_W-1:0] disp_per_sub;
    logic [PAIR_W-1:0] pair_step;
    logic last_disp;
    logic batch_full;
    slot_group_s [MAX_GROUPS-1:0] fill_groups;

    // configuration derived terms
    assign cfg_group_log = group_log2(dispatch_simd);
    assign cfg_sample_log = sample_log2(num_samples, sample_rate_shading);

    // samples of one subspan that fit in one dispatch
    assign per_sub_log = min_log(sample_log_reg, group_log_reg);

    // subspans packed per dispatch when all samples fit, else one
    assign subs_per_disp_log = (sample_log_reg <= group_log_reg) ?
                               LOG_W'(group_log_reg - sample_log_reg) : LOG_RESET;
    // dispatches needed per subspan when samples overflow the groups
    assign disp_per_sub_log = (sample_log_reg > group_log_reg) ?
                              LOG_W'(sample_log_reg - group_log_reg) : LOG_RESET;

    assign subs_per_disp = COUNT_W'(1) << subs_per_disp_log;
    assign disp_per_sub = DISP_W'(1) << disp_per_sub_log;

    // each dispatch consumes half as many sample pairs as it has groups
    // halve before narrowing: eight groups would wrap to zero in PAIR_W bits
    assign pair_step = PAIR_W'((COUNT_W'(1) << group_log_reg) >> 1);

    assign last_disp = (disp_idx_reg == DISP_W'(disp_per_sub - DISP_W'(1)));

    // handshakes
    assign sub_ready = clk_en && (state_reg == ST_COLLECT);
    assign take = sub_ready && sub_valid;
    assign first_take = take && (count_reg == COUNT_RESET);
    assign disp_valid = (state_reg == ST_ISSUE);
    assign send = clk_en && disp_valid && disp_ready;
    assign busy = (state_reg != ST_COLLECT) || (count_reg != COUNT_RESET);

    assign count_next = count_reg + COUNT_W'(1);

    // a batch closes when full, or early on flush with at least one subspan
    always_comb begin
        logic [COUNT_W-1:0] cap;
        cap = first_take ? (COUNT_W'(1) << ((cfg_sample_log <= cfg_group_log) ?
                            LOG_W'(cfg_group_log - cfg_sample_log) : LOG_RESET))
                         : subs_per_disp;
        batch_full = take && ((count_next == cap) || sub_flush);
    end

    // the slot layout for the current batch and start pair index
    slot_group_fill u_fill (
        .subspans(buf_reg),
        .subspan_count(count_reg),
        .group_log(group_log_reg),
        .per_sub_log(per_sub_log),
        .start_pair_index(pair_reg),
        .groups(fill_groups)
    );

    // sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_COLLECT: begin
                if (batch_full) begin
                    state_next = ST_BUILD;
                end
            end
            ST_BUILD: begin
                state_next = ST_ISSUE;
            end
            ST_ISSUE: begin
                if (send) begin
                    state_next = last_disp ? ST_COLLECT : ST_BUILD;
                end
            end
            default: begin
                state_next = ST_COLLECT;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_reg <= ST_COLLECT;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // configuration is frozen for the whole batch
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            simd_reg <= SIMD8;
            group_log_reg <= GROUP_LOG_SIMD8;
            sample_log_reg <= LOG_RESET;
        end else if (clk_en && first_take) begin
            simd_reg <= dispatch_simd;
            group_log_reg <= cfg_group_log;
            sample_log_reg <= cfg_sample_log;
        end
    end

    // subspan buffer, written by index in arrival order
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            buf_reg <= '0;
        end else if (clk_en && take) begin
            buf_reg[count_reg[2:0]] <= sub_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            count_reg <= COUNT_RESET;
        end else if (clk_en) begin
            if (take) begin
                count_reg <= count_next;
            end else if (send && last_disp) begin
                count_reg <= COUNT_RESET;
            end
        end
    end

    // dispatch index and start pair index walk upward per subspan
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            disp_idx_reg <= DISP_RESET;
            pair_reg <= PAIR_RESET;
        end else if (clk_en && send) begin
            if (last_disp) begin
                disp_idx_reg <= DISP_RESET;
                pair_reg <= PAIR_RESET;
            end else begin
                disp_idx_reg <= disp_idx_reg + DISP_W'(1);
                pair_reg <= pair_reg + pair_step;
            end
        end
    end

    // registered dispatch payload, built one cycle before it is offered
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            out_reg <= '0;
        end else if (clk_en && (state_reg == ST_BUILD)) begin
            out_reg.simd <= simd_reg;
            out_reg.start_pair_index <= pair_reg;
            out_reg.last_of_subspan <= last_disp;
            out_reg.group <= fill_groups;
        end
    end

    assign disp_data = out_reg;

endmodule : per_sample_slot_mapper
`default_nettype wire

// ==== sim/dispatch_sink.sv ====
// dispatcher stand-in taking dispatches promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module dispatch_sink (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic disp_valid,
    output logic disp_ready
);
    logic [1:0] wait_reg;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wait_reg <= 2'h0;
        end else if (disp_valid) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
    // when slow, a pending dispatch is taken one cycle in four
    assign disp_ready = !slow || wait_reg == 2'h3;
endmodule : dispatch_sink
`default_nettype wire

// ==== sim/per_sample_slot_mapper_checker.sv ====
// concurrent checks on the slot mapper ports
`timescale 1ns/1ps
`default_nettype none
module slot_mapper_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire slot_map_pkg::simd_e dispatch_simd,
    input wire slot_map_pkg::msaa_e num_samples,
    input wire logic sample_rate_shading,
    input wire logic sub_valid,
    input wire logic sub_ready,
    input wire logic disp_valid,
    input wire logic disp_ready,
    input wire slot_map_pkg::dispatch_s disp_data,
    input wire logic busy
);
    import slot_map_pkg::*;
    logic [2:0] slog, glog, ilog, step, top;
    logic [7:0] gv;
    logic take;
    always_comb begin
        slog = (sample_rate_shading && num_samples <= MS_16X) ? 3'(num_samples) : 3'h0;
        glog = (disp_data.simd == SIMD8) ? 3'h1 : (disp_data.simd == SIMD16) ? 3'h2 : 3'h3;
        ilog = (dispatch_simd == SIMD8) ? 3'h1 : (dispatch_simd == SIMD16) ? 3'h2 : 3'h3;
        step = 3'h1 << (glog - 3'h1);
        // start pair index of the final dispatch of a subspan
        top = (slog > glog) ? 3'((4'h1 << (slog - 3'h1)) - 4'(step)) : 3'h0;
        take = disp_valid && disp_ready && clk_en;
        for (int i = 0; i < 8; i++) begin
            gv[i] = disp_data.group[i].valid;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_mid_take;
        take && !disp_data.last_of_subspan;
    endsequence
    sequence s_next_issue;
        !disp_valid ##1 disp_valid;
    endsequence
    a_data_holds: assert property (disp_valid && !take |=> disp_valid && $stable(disp_data))
        else $error("dispatch changed while stalled");
    a_first_sample: assert property (disp_valid && gv[0] |->
        disp_data.group[0].sample == {disp_data.start_pair_index, 1'b0})
        else $error("group 0 sample not twice start pair index");
    a_pair_step: assert property (s_mid_take |=> s_next_issue ##0
        disp_data.start_pair_index == $past(disp_data.start_pair_index, 2) + step)
        else $error("start pair index step wrong");
    a_last_flag: assert property (disp_valid |->
        disp_data.last_of_subspan == (disp_data.start_pair_index == top))
        else $error("last flag on wrong dispatch");
    a_sub_blocked: assert property (disp_valid |-> !sub_ready)
        else $error("subspan taken while dispatching");
    a_ready_return: assert property (take && disp_data.last_of_subspan |=> sub_ready)
        else $error("input not reopened after last dispatch");
    a_batch_latency: assert property (sub_valid && sub_ready && slog >= ilog |=> s_next_issue)
        else $error("single subspan dispatch late");
    a_groups_unused: assert property (disp_valid |-> gv[0] && (gv >> (4'h1 << glog)) == 8'h0)
        else $error("group valid bits beyond width");
    a_busy_pending: assert property (disp_valid |-> busy)
        else $error("busy low with dispatch pending");
endmodule : slot_mapper_checker
bind per_sample_slot_mapper slot_mapper_checker slot_mapper_checker_i (.core_clk(core_clk),
    .resetn(resetn), .clk_en(clk_en), .dispatch_simd(dispatch_simd),
    .num_samples(num_samples), .sample_rate_shading(sample_rate_shading),
    .sub_valid(sub_valid), .sub_ready(sub_ready), .disp_valid(disp_valid),
    .disp_ready(disp_ready), .disp_data(disp_data), .busy(busy));
`default_nettype wire

// ==== sim/per_sample_slot_mapper_test.sv ====
// self-checking bench for the slot mapper
`timescale 1ns/1ps
`default_nettype none
module per_sample_slot_mapper_test;
    import slot_map_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic sub_valid = 1'b0;
    logic srs = 1'b0;
    logic slow = 1'b0;
    logic flush = 1'b0;
    logic sub_ready, disp_valid, disp_ready, busy;
    simd_e simd = SIMD8;
    msaa_e ms = MS_1X;
    subspan_s sub = '0;
    subspan_s s[8];
    dispatch_s d;
    dispatch_s q[$];
    logic [31:0] seed = 32'h6748618b;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    always #2.5 core_clk = ~core_clk;
    per_sample_slot_mapper per_sample_slot_mapper_i (.core_clk(core_clk), .resetn(resetn),
        .clk_en(1'b1), .dispatch_simd(simd), .num_samples(ms), .sample_rate_shading(srs),
        .sub_valid(sub_valid), .sub_ready(sub_ready), .sub_data(sub), .sub_flush(flush),
        .disp_valid(disp_valid), .disp_ready(disp_ready), .disp_data(d), .busy(busy));
    dispatch_sink dispatch_sink_i (.core_clk(core_clk), .resetn(resetn), .slow(slow),
        .disp_valid(disp_valid), .disp_ready(disp_ready));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (resetn && disp_valid === 1'b1 && disp_ready === 1'b1)
            q.push_back(d);
        if (cyc == 10000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        int gl, sl, nb, nd, gs, st, k, w;
        logic [31:0] r;
        dispatch_s x;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        // all widths and sample counts, then random per-pixel batches, the last ones cut by flush
        for (int i = 0; i < 36; i++) begin
            r = rnd();
            gl = (i < 30 ? i % 3 : int'(r % 3)) + 1;
            sl = i < 30 ? (i / 3) % 5 : 0;
            simd <= simd_e'(gl - 1);
            ms <= msaa_e'(i < 30 ? sl : int'(r[7:5] % 5));
            srs <= (i < 30);
            slow <= i[0];
            nb = sl <= gl ? 1 << (gl - sl) : 1;
            if (i >= 33)
                nb = 1 + int'(r[10:8]) % nb;
            nd = sl > gl ? 1 << (sl - gl) : 1;
            gs = sl < gl ? 1 << sl : 1 << gl;
            st = nd > 1 ? 1 << (gl - 1) : 0;
            sub_valid <= 1'b1;
            for (k = 0; k < nb; k++) begin
                r = rnd();
                s[k] = subspan_s'(r[15:0]);
                sub <= s[k];
                flush <= (i >= 33 && k == nb - 1);
                do @(posedge core_clk); while (sub_ready !== 1'b1);
            end
            sub_valid <= 1'b0;
            flush <= 1'b0;
            for (w = 0; w < 300 && q.size() < nd; w++) @(posedge core_clk);
            check(16'(q.size()), 16'(nd));
            for (int j = 0; j < nd && q.size() > 0; j++) begin
                x = q.pop_front();
                check(16'(x.simd), 16'(gl - 1));
                check(16'(x.start_pair_index), 16'(j * st));
                check(16'(x.last_of_subspan), 16'(j == nd - 1));
                for (int g = 0; g < 8; g++) begin
                    check(16'(x.group[g].valid), 16'(g < (1 << gl) && g / gs < nb));
                    if (g < (1 << gl) && g / gs < nb) begin
                        check({x.group[g].tag, x.group[g].pixel_mask}, s[g / gs]);
                        check(16'(x.group[g].sample), 16'(j * st * 2 + g % gs));
                    end
                end
            end
            // once the last dispatch is gone the block is idle and open again
            @(negedge core_clk);
            check(16'(busy), 16'h0);
            check(16'(sub_ready), 16'h1);
            @(posedge core_clk);
            $display("test %0d done", i);
        end
        test_done();
    end
endmodule : per_sample_slot_mapper_test
`default_nettype wire
